// >>> crcu_pkg.sv
// constants for the byte-wide checksum unit with flash scan
package crcu_pkg;
    // register addresses on the special-function bus
    localparam logic [7:0] ADDR_RESULT_PORT = 8'h91;
    localparam logic [7:0] ADDR_CONTROL = 8'h92;
    localparam logic [7:0] ADDR_INPUT_BYTE = 8'h93;
    localparam logic [7:0] ADDR_BIT_REVERSER = 8'h95;
    localparam logic [7:0] ADDR_SCAN_CONTROL = 8'h96;
    localparam logic [7:0] ADDR_SCAN_COUNT = 8'h97;

    // control register fields
    localparam int CTL_POLY_BIT = 4;
    localparam int CTL_INIT_BIT = 3;
    localparam int CTL_SEED_BIT = 2;
    localparam int CTL_PTR_LSB = 0;

    // scan control register fields
    localparam int SCAN_ENABLE_BIT = 7;
    localparam int SCAN_DONE_BIT = 6;
    localparam int FIELD_LSB = 0;
    localparam int FIELD_W = 6;

    // polynomials and seeds
    localparam logic [15:0] POLY16 = 16'h1021;
    localparam logic [31:0] POLY32 = 32'h04c11db7;
    localparam logic [31:0] POLY32_REFLECTED = 32'hedb88320;
    localparam logic [31:0] SEED_ZEROS = 32'h00000000;
    localparam logic [31:0] SEED_ONES = 32'hffffffff;

    // result pointer codes
    localparam logic [1:0] PTR_B0 = 2'h0;
    localparam logic [1:0] PTR_B1 = 2'h1;
    localparam logic [1:0] PTR_B2 = 2'h2;
    localparam logic [1:0] PTR_B3 = 2'h3;
    localparam logic [1:0] PTR_STEP = 2'h1;

    // flash block geometry: 1024-byte blocks
    localparam int BLOCK_SHIFT = 10;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_FIELD = 6'h00;
    localparam logic RST_DONE = 1'b1;
endpackage

// >>> crcu_flash_scan.sv
// checksum engine with pointer readout, bit reverser and automatic flash scan
// Notes on behaviour
// [R1] poly select 0 gives 32-bit poly and result, 1 gives 16-bit poly and result.
// [R2] writing 1 to init bit loads whole result with the chosen seed.
// [R3] seed select 0 loads all zeros, 1 loads all ones.
// [R4] pointer picks byte: 0 low, 1 next, 2 and 3 depend on result width.
// [R5] pointer advances after every read or write of the result port.
// [R6] reading the result port returns the byte the pointer selects.
// [R7] each byte written to the input register is folded into the result.
// [R8] software waits one instruction after init before reading the result port.
// [R9] with scan enabled and a nonzero block count, any control write starts a flash scan.
// [R10] done flag is 0 while scanning, resets to 1, reads always give 1.
// [R11] first scan address is start block times 1024.
// [R12] last scan address is (start plus count) times 1024 minus one.
// [R13] byte written to the bit reverser reads back bit-reversed.
// [R14] software issues only benign instructions for three cycles after a scan start.
// [R15] 16-bit mode: xor byte into upper byte, shift left eight times with 0x1021.
// [R16] 32-bit mode: xor byte into low byte, shift right eight times with reflected poly.
// [R17] pointer wraps from 3 back to 0.
// [R18] scan feeds flash bytes in ascending order through the engine, then sets done.
`timescale 1ns/1ps

module crcu_flash_scan
    import crcu_pkg::*;
#(
    parameter int AW = 17
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWe,
    input wire logic sfrRe,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic coreStall,
    output logic [AW-1:0] flashAddr,
    output logic flashRe,
    input wire logic [7:0] flashData
);

    typedef enum logic [2:0] {
        SC_IDLE = 3'b001,
        SC_READ = 3'b010,
        SC_FOLD = 3'b100
    } crcu_scan_t;

    typedef struct packed {
        crcu_scan_t scan;
        logic [31:0] result;
        logic poly_select;
        logic seedSel;
        logic [1:0] ptr;
        logic [7:0] inputByte;
        logic [7:0] flipByte;
        logic scanEnable;
        logic scanDone;
        logic [5:0] startBlock;
        logic [5:0] blockCount;
        logic [AW-1:0] addr;
        logic [AW-1:0] lastAddr;
        logic [7:0] rdata;
        logic stall;
        logic rdStrobe;
    } crcu_state_t;

    crcu_state_t st;
    crcu_state_t next_st;

    // one input byte through the 16-bit engine
    function automatic logic [15:0] crc16Step(input logic [15:0] acc, input logic [7:0] b);
        logic [15:0] a;
        a = acc ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            if (a[15]) begin
                a = {a[14:0], 1'b0} ^ POLY16; // [R15]
            end else begin
                a = {a[14:0], 1'b0};
            end
        end
        return a;
    endfunction

    // one input byte through the reflected 32-bit engine
    function automatic logic [31:0] crc32Step(input logic [31:0] acc, input logic [7:0] b);
        logic [31:0] a;
        a = acc ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            if (a[0]) begin
                a = {1'b0, a[31:1]} ^ POLY32_REFLECTED; // [R16]
            end else begin
                a = {1'b0, a[31:1]};
            end
        end
        return a;
    endfunction

    // fold a byte using the selected width; 16-bit mode keeps upper half clear
    function automatic logic [31:0] foldByte(input logic [31:0] res, input logic sel16,
                                             input logic [7:0] b);
        logic [31:0] r;
        if (sel16) begin
            r = {16'h0000, crc16Step(res[15:0], b)}; // [R1]
        end else begin
            r = crc32Step(res, b); // [R1]
        end
        return r;
    endfunction

    // bit index of the byte the pointer selects
    function automatic int byteLsb(input logic [1:0] p, input logic sel16);
        int l;
        unique case (p)
            PTR_B0: l = 0;
            PTR_B1: l = 8;
            PTR_B2: l = sel16 ? 0 : 16;
            PTR_B3: l = sel16 ? 8 : 24;
        endcase
        return l; // [R4]
    endfunction

    function automatic logic [7:0] bitReverse(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    // the pointer walks the four result bytes and wraps from 3 back to 0
    function automatic logic [1:0] ptrAdvance(input logic [1:0] p);
        logic [1:0] n;
        n = p + PTR_STEP; // [R5] [R17]
        return n;
    endfunction

    // first byte address of a flash block
    function automatic logic [AW-1:0] blockBase(input logic [6:0] blk);
        logic [AW-1:0] a;
        a = AW'(blk) << BLOCK_SHIFT;
        return a;
    endfunction

    // control readback: init and reserved bits always read 0
    function automatic logic [7:0] controlByte(input logic poly, input logic seed,
                                               input logic [1:0] p);
        logic [7:0] r;
        r = RST_BYTE;
        r[CTL_POLY_BIT] = poly;
        r[CTL_SEED_BIT] = seed;
        r[CTL_PTR_LSB +: 2] = p;
        return r;
    endfunction

    // scan readback: enable and done flags above a six-bit field
    function automatic logic [7:0] scanByte(input logic en, input logic done,
                                            input logic [FIELD_W-1:0] field);
        logic [7:0] r;
        r = RST_BYTE;
        r[SCAN_ENABLE_BIT] = en;
        r[SCAN_DONE_BIT] = done;
        r[FIELD_LSB +: FIELD_W] = field;
        return r;
    endfunction

    always_comb begin
        logic wr;
        logic rd;
        int lsb;
        logic [6:0] endBlock;
        wr = 1'b0;
        rd = 1'b0;
        lsb = 0;
        endBlock = 7'h00;
        next_st = st;
        next_st.rdStrobe = 1'b0;
        lsb = byteLsb(st.ptr, st.poly_select);
        unique case (st.scan)
            SC_IDLE: begin
                wr = sfrWe;
                rd = sfrRe;
                // registers answer only while idle; during a scan the core is stalled
                if (rd) begin
                    next_st.rdata = RST_BYTE;
                    unique case (sfrAddr)
                        ADDR_RESULT_PORT: begin
                            next_st.rdata = st.result[lsb +: 8]; // [R6]
                            next_st.ptr = ptrAdvance(st.ptr); // [R5] [R17]
                        end
                        ADDR_CONTROL: begin
                            next_st.rdata = controlByte(st.poly_select, st.seedSel, st.ptr);
                        end
                        ADDR_INPUT_BYTE: next_st.rdata = st.inputByte;
                        ADDR_BIT_REVERSER: next_st.rdata = st.flipByte; // [R13]
                        ADDR_SCAN_CONTROL: begin
                            next_st.rdata = scanByte(st.scanEnable, st.scanDone, // [R10]
                                                     st.startBlock);
                        end
                        ADDR_SCAN_COUNT: next_st.rdata = scanByte(1'b0, 1'b0, st.blockCount);
                        default: next_st.rdata = RST_BYTE;
                    endcase
                end
                if (wr) begin
                    unique case (sfrAddr)
                        ADDR_RESULT_PORT: begin
                            // a write replaces the selected byte and steps the pointer
                            next_st.result[lsb +: 8] = sfrWdata;
                            next_st.ptr = ptrAdvance(st.ptr); // [R5] [R17]
                        end
                        ADDR_CONTROL: begin
                            next_st.poly_select = sfrWdata[CTL_POLY_BIT]; // [R1]
                            next_st.seedSel = sfrWdata[CTL_SEED_BIT];
                            next_st.ptr = sfrWdata[CTL_PTR_LSB +: 2];
                            if (sfrWdata[CTL_INIT_BIT]) begin
                                // [R2] [R3]
                                next_st.result = sfrWdata[CTL_SEED_BIT] ? SEED_ONES
                                                                        : SEED_ZEROS;
                            end
                            // init lands first, so a scan started here uses the new seed
                            if (st.scanEnable) begin
                                endBlock = {1'b0, st.startBlock} + {1'b0, st.blockCount};
                                next_st.addr = blockBase({1'b0, st.startBlock}); // [R11]
                                next_st.lastAddr = blockBase(endBlock) - AW'(1); // [R12]
                                next_st.scanDone = 1'b0; // [R10]
                                next_st.stall = 1'b1;
                                if (st.blockCount == RST_FIELD) begin
                                    next_st.scanDone = 1'b1;
                                    next_st.stall = 1'b0;
                                end else begin
                                    next_st.scan = SC_READ; // [R9]
                                    next_st.rdStrobe = 1'b1;
                                end
                            end
                        end
                        ADDR_INPUT_BYTE: begin
                            next_st.inputByte = sfrWdata;
                            next_st.result = foldByte(st.result, st.poly_select, sfrWdata); // [R7]
                        end
                        ADDR_BIT_REVERSER: next_st.flipByte = bitReverse(sfrWdata); // [R13]
                        ADDR_SCAN_CONTROL: begin
                            next_st.scanEnable = sfrWdata[SCAN_ENABLE_BIT];
                            next_st.startBlock = sfrWdata[FIELD_LSB +: FIELD_W];
                        end
                        ADDR_SCAN_COUNT: next_st.blockCount = sfrWdata[FIELD_LSB +: FIELD_W];
                        default: next_st.rdata = st.rdata;
                    endcase
                end
            end
            SC_READ: begin
                // flash answers one cycle after the read strobe
                next_st.scan = SC_FOLD;
            end
            SC_FOLD: begin
                // the byte asked for at the last strobe stands on flashData now
                next_st.result = foldByte(st.result, st.poly_select, flashData); // [R18]
                if (st.addr == st.lastAddr) begin
                    next_st.scan = SC_IDLE;
                    next_st.scanDone = 1'b1; // [R18]
                    next_st.stall = 1'b0;
                end else begin
                    next_st.addr = st.addr + AW'(1); // [R18]
                    next_st.scan = SC_READ;
                    next_st.rdStrobe = 1'b1;
                end
            end
            default: begin
                // an illegal state code falls back to idle and releases the core
                next_st.scan = SC_IDLE;
                next_st.stall = 1'b0;
                next_st.scanDone = RST_DONE;
            end
        endcase
    end

    // ce low freezes every field, the one-cycle flash strobe included
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.scan <= SC_IDLE;
            st.result <= SEED_ZEROS;
            st.poly_select <= 1'b0;
            st.seedSel <= 1'b0;
            st.ptr <= PTR_B0;
            st.inputByte <= RST_BYTE;
            st.flipByte <= RST_BYTE;
            st.scanEnable <= 1'b0;
            st.scanDone <= RST_DONE; // [R10]
            st.startBlock <= RST_FIELD;
            st.blockCount <= RST_FIELD;
            st.addr <= '0;
            st.lastAddr <= '0;
            st.rdata <= RST_BYTE;
            st.stall <= 1'b0;
            st.rdStrobe <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign sfrRdata = st.rdata;
    assign coreStall = st.stall;
    assign flashAddr = st.addr;
    assign flashRe = st.rdStrobe;

endmodule

// >>> crcu_flash_model.sv
// flash array model answering each read pulse one cycle later
`timescale 1ns/1ps
module crcu_flash_model #(
    parameter int AW = 17
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic [AW-1:0] flashAddr,
    input wire logic flashRe,
    output logic [7:0] flashData
);
    logic [7:0] held = 8'h00;
    assign flashData = held;
    // data is valid from a sampled pulse to the next enabled edge; other enabled edges invert it, ce low holds it
    always @(posedge clk) begin
        if (ce) begin
            held <= flashRe ? (8'(flashAddr) ^ 8'(flashAddr >> 8) ^ 8'h5a) : ~held;
        end
    end
endmodule

// >>> crcu_flash_scan_props.sv
// port checker for the checksum unit, bound to the design
`timescale 1ns/1ps
module crcu_flash_scan_props
    import crcu_pkg::*;
#(
    parameter int AW = 17
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWe,
    input wire logic sfrRe,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic coreStall,
    input wire logic [AW-1:0] flashAddr,
    input wire logic flashRe,
    input wire logic [7:0] flashData
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic rdOk;
    logic wrRev;
    logic [7:0] revData;
    assign rdOk = ce && sfrRe && !coreStall;
    assign wrRev = ce && sfrWe && !coreStall && sfrAddr == ADDR_BIT_REVERSER;
    assign revData = {<<{sfrWdata}};
    logic [5:0] startSeen;
    // start block last written to the scan control register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            startSeen <= RST_FIELD;
        end else if (ce && sfrWe && !coreStall && sfrAddr == ADDR_SCAN_CONTROL) begin
            startSeen <= sfrWdata[FIELD_LSB +: FIELD_W];
        end
    end
    rdata_hold_a: assert property (!rdOk |=> $stable(sfrRdata))
        else $error("read data moved without a read");
    unmapped_read_a: assert property (rdOk && sfrAddr == 8'h94 |=> sfrRdata == 8'h00)
        else $error("unmapped read not zero");
    done_reads_a: assert property (rdOk && sfrAddr == ADDR_SCAN_CONTROL |=> sfrRdata[6])
        else $error("done flag read as zero");
    init_reads_a: assert property (rdOk && sfrAddr == ADDR_CONTROL |=>
        sfrRdata[7:3] == 5'h00 || sfrRdata[7:3] == 5'h02)
        else $error("control init or reserved bits read set");
    reverse_read_a: assert property (wrRev ##1 !wrRev
        ##1 rdOk && sfrAddr == ADDR_BIT_REVERSER |=> sfrRdata == $past(revData, 3))
        else $error("reverser readback wrong");
    pulse_gap_a: assert property (ce && flashRe |=> !flashRe)
        else $error("flash pulses back to back");
    re_in_scan_a: assert property (flashRe |-> coreStall)
        else $error("flash read outside a scan");
    first_addr_a: assert property ($rose(coreStall) |->
        flashRe && flashAddr == (AW'(startSeen) << BLOCK_SHIFT))
        else $error("scan not starting at the start block");
    addr_step_a: assert property (ce && flashRe ##1 ce ##1 flashRe
        |-> flashAddr == $past(flashAddr, 2) + 1'b1)
        else $error("flash address not ascending by one");
    stall_end_a: assert property ($fell(coreStall) |-> !flashRe && !$past(flashRe))
        else $error("scan ended before last byte folded");
endmodule
bind crcu_flash_scan crcu_flash_scan_props #(.AW(AW)) u_props (.clk, .nrst, .ce, .sfrAddr,
    .sfrWe, .sfrRe, .sfrWdata, .sfrRdata, .coreStall, .flashAddr, .flashRe, .flashData);

// >>> tb_crcu_flash_scan.sv
// self-checking bench for the checksum unit with flash scan
`timescale 1ns/1ps
module tb_crcu_flash_scan import crcu_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, sfrWe = 1'b0, sfrRe = 1'b0, coreStall, flashRe;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, flashData;
    logic [16:0] flashAddr;
    logic [31:0] seed = 32'h0000fc4f;
    int miscompares = 0, compares = 0, cyc = 0, stallCycles = 0;
    always #2 clk = ~clk;
    crcu_flash_scan #(.AW(17)) dut (.clk(clk), .nrst(nrst), .ce(ce), .sfrAddr(sfrAddr),
        .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .coreStall(coreStall), .flashAddr(flashAddr), .flashRe(flashRe), .flashData(flashData));
    crcu_flash_model #(.AW(17)) flash (.clk(clk), .ce(ce), .flashAddr(flashAddr),
        .flashRe(flashRe), .flashData(flashData));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [31:0] fold(logic [31:0] a, logic [7:0] b, logic p16);
        logic [31:0] c;
        c = p16 ? {16'h0000, a[15:0] ^ {b, 8'h00}} : a ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            if (p16) c = {16'h0000, c[15] ? ({c[14:0], 1'b0} ^ POLY16) : {c[14:0], 1'b0}};
            else c = c[0] ? ((c >> 1) ^ POLY32_REFLECTED) : (c >> 1);
        end
        return c;
    endfunction
    function automatic logic [7:0] pick(logic [31:0] r, logic [1:0] p, logic p16);
        int k;
        k = p16 ? p[0] : p;
        return r[8 * k +: 8];
    endfunction
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(logic we, logic [7:0] a, logic [7:0] d, output logic [7:0] g);
        sfrAddr = a;
        sfrWdata = d;
        sfrWe = we;
        sfrRe = !we;
        @(posedge clk);
        #1;
        g = sfrRdata;
        sfrWe = 1'b0;
        sfrRe = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(string n, logic [7:0] a, logic [7:0] e);
        logic [7:0] g;
        acc(1'b0, a, 8'h00, g);
        cmp(n, {24'h0, e}, {24'h0, g});
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (coreStall === 1'b1 && ce) stallCycles++;
        if (cyc == 32'h00004e20) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        logic [7:0] g, b, e;
        logic [31:0] r;
        logic p16;
        int stall0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk("control", ADDR_CONTROL, 8'h00);
        chk("input", ADDR_INPUT_BYTE, RST_BYTE);
        chk("reverser", ADDR_BIT_REVERSER, RST_BYTE);
        chk("scan control", ADDR_SCAN_CONTROL, 8'h40);
        chk("scan count", ADDR_SCAN_COUNT, 8'h00);
        chk("unmapped", 8'h94, 8'h00);
        chk("result", ADDR_RESULT_PORT, 8'h00);
        chk("control", ADDR_CONTROL, 8'h01);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            p16 = m[0];
            r = m[1] ? SEED_ONES : SEED_ZEROS;
            // trailing idle cycle of acc lets one instruction pass before reading
            acc(1'b1, ADDR_CONTROL, {3'h0, p16, 1'b1, m[1], 2'h0}, g);
            for (int i = 0; i < 6; i++) begin
                b = (i == 0) ? 8'h63 : rnd();
                acc(1'b1, ADDR_INPUT_BYTE, b, g);
                r = fold(r, b, p16);
            end
            for (int k = 0; k < 5; k++) begin
                chk("result byte", ADDR_RESULT_PORT, pick(r, k[1:0], p16));
            end
        end
        acc(1'b1, ADDR_CONTROL, 8'h01, g);
        b = rnd();
        acc(1'b1, ADDR_RESULT_PORT, b, g);
        chk("control", ADDR_CONTROL, 8'h02);
        acc(1'b1, ADDR_CONTROL, 8'h01, g);
        chk("result byte", ADDR_RESULT_PORT, b);
        for (int i = 0; i < 5; i++) begin
            b = (i == 0) ? 8'hc0 : rnd();
            e = {<<{b}};
            acc(1'b1, ADDR_BIT_REVERSER, b, g);
            chk("reverser", ADDR_BIT_REVERSER, e);
        end
        $display("test stream done");
        acc(1'b1, ADDR_SCAN_CONTROL, 8'h83, g);
        acc(1'b1, ADDR_SCAN_COUNT, 8'h00, g);
        acc(1'b1, ADDR_CONTROL, 8'h0c, g);
        cmp("stall", 32'h0, {31'h0, coreStall});
        r = SEED_ONES;
        acc(1'b1, ADDR_SCAN_COUNT, 8'h01, g);
        stall0 = stallCycles;
        // no access until the stall ends, so the three cycles after the start stay benign
        acc(1'b1, ADDR_CONTROL, 8'h0c, g);
        for (int i = 0; i < 6000 && coreStall !== 1'b0; i++) begin
            @(posedge clk);
            #1;
            ce = rnd() > 8'h40;
        end
        ce = 1'b1;
        for (int a = 3072; a < 4096; a++) begin
            r = fold(r, 8'(a) ^ 8'(a >> 8) ^ 8'h5a, 1'b0);
        end
        cmp("scan cycles", 32'h00000800, stallCycles - stall0);
        chk("scan control", ADDR_SCAN_CONTROL, 8'hc3);
        acc(1'b1, ADDR_SCAN_CONTROL, 8'h03, g);
        acc(1'b1, ADDR_CONTROL, 8'h04, g);
        for (int k = 0; k < 4; k++) begin
            chk("scan result", ADDR_RESULT_PORT, pick(r, k[1:0], 1'b0));
        end
        $display("test scan done");
        finish_test();
    end
endmodule
